// file: hdl/esr_edge_det.sv
// Two-stage synchroniser and polarity edge detector, one per pin.
// Assumes asynchronous pin levels and a polarity that is static per edge.
`timescale 1ns/1ps
`default_nettype none
module esr_edge_det #(
    parameter int N = 15
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Pins, polarities and pulses.
    esr_edge_if.det eif
);
    // Refuse an empty pin vector when the design is built.
    if (N < 1) begin : g_bad_n
        $error("esr_edge_det: N must be at least one.");
    end
    logic [N-1:0] meta_ff;
    logic [N-1:0] sync_ff;
    logic [N-1:0] last_ff;
    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_ff <= '0;
            sync_ff <= '0;
            last_ff <= '0;
        end else begin
            meta_ff <= eif.pins;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end
    // One pulse per qualifying edge: rising when polarity is 1.
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_edge
            assign eif.pulse[g] = eif.pol[g] ? (sync_ff[g] & ~last_ff[g])
                                             : (~sync_ff[g] & last_ff[g]);
        end
    endgenerate
endmodule : esr_edge_det
`default_nettype wire

// file: hdl/esr_edge_if.sv
// Interface carrying pin levels and edge pulses between detector and top.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface esr_edge_if #(parameter int N = 15);
    logic [N-1:0] pins;
    logic [N-1:0] pol;
    logic [N-1:0] pulse;
    modport det (input pins, input pol, output pulse);
    modport top (output pins, output pol, input pulse);
endinterface : esr_edge_if
`default_nettype wire

// file: hdl/esr_pkg.sv
// Package of the edge select and enable register block.
// Assumes an 8-bit register port with one-cycle strobes.
package esr_pkg;
    // Register offsets on the plain register port.
    localparam logic [2:0] ESR_OFS_POL_PRI = 3'h0;
    localparam logic [2:0] ESR_OFS_POL_SEC = 3'h1;
    localparam logic [2:0] ESR_OFS_EN_FIRST = 3'h2;
    localparam logic [2:0] ESR_OFS_EN_SECOND = 3'h3;
    localparam logic [2:0] ESR_OFS_FLAGS_A = 3'h4;
    localparam logic [2:0] ESR_OFS_FLAGS_B = 3'h5;
    localparam logic [2:0] ESR_OFS_CTRL = 3'h6;
    // Reset values.
    localparam logic [7:0] ESR_RST_POL_PRI = 8'h70;
    localparam logic [7:0] ESR_RST_POL_SEC = 8'h00;
    localparam logic [7:0] ESR_RST_EN_FIRST = 8'h10;
    localparam logic [7:0] ESR_RST_EN_SECOND = 8'h00;
    // Fixed and writable bit masks.
    localparam logic [7:0] ESR_POL_PRI_WMASK = 8'h0f;
    localparam logic [7:0] ESR_POL_PRI_FIXED = 8'h70;
    localparam logic [7:0] ESR_EN_FIRST_WMASK = 8'hcf;
    localparam logic [7:0] ESR_EN_FIRST_FIXED = 8'h10;
    localparam logic [7:0] ESR_EN_SECOND_WMASK = 8'hd0;
    // Field positions.
    localparam int ESR_BIT_TB1 = 7;
    localparam int ESR_BIT_TA = 6;
    localparam int ESR_BIT_DT = 7;
    localparam int ESR_BIT_AD = 6;
    localparam int ESR_BIT_S1 = 4;
    localparam int ESR_BIT_SEC7 = 7;
    localparam int ESR_BIT_SEC6 = 6;
    localparam int ESR_BIT_SEC5 = 5;
    localparam int ESR_BIT_GMASK = 0;
endpackage : esr_pkg

// file: hdl/esr_regs.sv
// Edge polarity and request enable registers with request flags.
// Assumes a plain register port on clk; pins are asynchronous.
//
// Design decisions made here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module esr_regs
    import esr_pkg::*;
#(
    parameter int NPRI = 4,
    parameter int NSEC = 8
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Register port.
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // External pins.
    input wire logic [NPRI-1:0] primary_pins,
    input wire logic [NSEC-1:0] secondary_pins,
    input wire logic timer_y_input_pin,
    input wire logic timer_b_input_pin,
    input wire logic converter_trigger_pin,
    // Internal event pulses from other blocks.
    input wire logic timer_b1_overflow,
    input wire logic timer_a_overflow,
    input wire logic direct_transfer_event,
    input wire logic converter_end_event,
    input wire logic serial1_done_event,
    // Edge pulses for the timer and converter.
    output logic timer_y_edge,
    output logic timer_b_edge,
    output logic converter_trigger_edge,
    // Secondary pin edge pulses for the secondary flag block.
    output logic [NSEC-1:0] secondary_edges,
    // Requests to the CPU acceptance logic.
    output logic [NPRI+5:0] cpu_requests,
    output logic cpu_request_any
);
    // Refuse sizes that the fixed register layout cannot serve.
    if (NPRI != 4 || NSEC != 8) begin : g_bad_size
        $error("esr_regs: NPRI=4, NSEC=8 only.");
    end
    localparam int NP = NPRI + NSEC + 3;
    logic [7:0] pol_pri_ff;
    logic [7:0] pol_sec_ff;
    logic [7:0] en_first_ff;
    logic [7:0] en_second_ff;
    logic [7:0] flags_a_ff;
    logic [7:0] flags_b_ff;
    logic gmask_ff;
    logic [7:0] nxt_flags_a;
    logic [7:0] nxt_flags_b;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic [7:0] rd_mux;
    logic [NPRI+5:0] nxt_req;
    logic wr_pri;
    logic wr_sec;
    logic wr_en1;
    logic wr_en2;
    logic wr_fa;
    logic wr_fb;
    logic wr_ctl;

    esr_edge_if #(.N(NP)) eif ();

    // Pins and shared polarity bits towards the detector.
    assign eif.pins = {converter_trigger_pin, timer_b_input_pin,
                       timer_y_input_pin, secondary_pins, primary_pins};
    assign eif.pol = {pol_sec_ff[ESR_BIT_SEC5],
                      pol_sec_ff[ESR_BIT_SEC6],
                      pol_sec_ff[ESR_BIT_SEC7],
                      pol_sec_ff,
                      pol_pri_ff[NPRI-1:0]};

    esr_edge_det #(.N(NP)) u_det (
        .clk(clk),
        .nrst(nrst),
        .eif(eif)
    );

    // Write strobes per register.
    assign wr_pri = reg_wr && (reg_addr == ESR_OFS_POL_PRI);
    assign wr_sec = reg_wr && (reg_addr == ESR_OFS_POL_SEC);
    assign wr_en1 = reg_wr && (reg_addr == ESR_OFS_EN_FIRST);
    assign wr_en2 = reg_wr && (reg_addr == ESR_OFS_EN_SECOND);
    assign wr_fa = reg_wr && (reg_addr == ESR_OFS_FLAGS_A);
    assign wr_fb = reg_wr && (reg_addr == ESR_OFS_FLAGS_B);
    assign wr_ctl = reg_wr && (reg_addr == ESR_OFS_CTRL);

    // Primary polarity: only bits 3..0 take writes.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pol_pri_ff <= ESR_RST_POL_PRI;
        end else if (wr_pri) begin
            pol_pri_ff <= (reg_wdata & ESR_POL_PRI_WMASK)
                          | ESR_POL_PRI_FIXED;
        end
    end

    // Secondary polarity: every bit writable.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pol_sec_ff <= ESR_RST_POL_SEC;
        end else if (wr_sec) begin
            pol_sec_ff <= reg_wdata;
        end
    end

    // First enable register with fixed bits 5 and 4.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_first_ff <= ESR_RST_EN_FIRST;
        end else if (wr_en1) begin
            en_first_ff <= (reg_wdata & ESR_EN_FIRST_WMASK)
                           | ESR_EN_FIRST_FIXED;
        end
    end

    // Second enable register: bits 7, 6 and 4 only.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_second_ff <= ESR_RST_EN_SECOND;
        end else if (wr_en2) begin
            en_second_ff <= reg_wdata & ESR_EN_SECOND_WMASK;
        end
    end

    // Global acceptance mask, set at reset like the CPU mask bit.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gmask_ff <= 1'b1;
        end else if (wr_ctl) begin
            gmask_ff <= reg_wdata[ESR_BIT_GMASK];
        end
    end

    // Flag set terms; primary pins set flags whatever the enable holds.
    always_comb begin
        set_a = 8'h00;
        set_a[NPRI-1:0] = eif.pulse[NPRI-1:0];
        set_a[ESR_BIT_TB1] = timer_b1_overflow;
        set_a[ESR_BIT_TA] = timer_a_overflow;
        set_b = 8'h00;
        set_b[ESR_BIT_DT] = direct_transfer_event;
        set_b[ESR_BIT_AD] = converter_end_event;
        set_b[ESR_BIT_S1] = serial1_done_event;
    end

    // Writing 0 clears a flag, writing 1 keeps it; a set wins over a clear.
    always_comb begin
        nxt_flags_a = flags_a_ff;
        nxt_flags_b = flags_b_ff;
        if (wr_fa) begin
            nxt_flags_a = flags_a_ff & reg_wdata;
        end
        if (wr_fb) begin
            nxt_flags_b = flags_b_ff & reg_wdata;
        end
        nxt_flags_a = (nxt_flags_a | set_a) & ESR_EN_FIRST_WMASK;
        nxt_flags_b = (nxt_flags_b | set_b) & ESR_EN_SECOND_WMASK;
    end

    // Flags are not cleared by acceptance, only by software.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flags_a_ff <= 8'h00;
            flags_b_ff <= 8'h00;
        end else begin
            flags_a_ff <= nxt_flags_a;
            flags_b_ff <= nxt_flags_b;
        end
    end

    // Requests: flag and enable both set, and the mask clear.
    always_comb begin
        nxt_req = '0;
        nxt_req[NPRI-1:0] = flags_a_ff[NPRI-1:0]
                            & en_first_ff[NPRI-1:0];
        nxt_req[NPRI] = flags_a_ff[ESR_BIT_TA]
                        & en_first_ff[ESR_BIT_TA];
        nxt_req[NPRI+1] = flags_a_ff[ESR_BIT_TB1]
                          & en_first_ff[ESR_BIT_TB1];
        nxt_req[NPRI+2] = flags_b_ff[ESR_BIT_S1]
                          & en_second_ff[ESR_BIT_S1];
        nxt_req[NPRI+3] = flags_b_ff[ESR_BIT_AD]
                          & en_second_ff[ESR_BIT_AD];
        nxt_req[NPRI+4] = flags_b_ff[ESR_BIT_DT]
                          & en_second_ff[ESR_BIT_DT];
        nxt_req[NPRI+5] = 1'b0;
        if (gmask_ff) begin
            nxt_req = '0;
        end
    end

    // Registered request outputs.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cpu_requests <= '0;
            cpu_request_any <= 1'b0;
        end else begin
            cpu_requests <= nxt_req;
            cpu_request_any <= |nxt_req;
        end
    end

    // Registered edge pulses for the timer, converter and secondary flags.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            secondary_edges <= '0;
            timer_y_edge <= 1'b0;
            timer_b_edge <= 1'b0;
            converter_trigger_edge <= 1'b0;
        end else begin
            secondary_edges <= eif.pulse[NPRI+NSEC-1:NPRI];
            timer_y_edge <= eif.pulse[NPRI+NSEC];
            timer_b_edge <= eif.pulse[NPRI+NSEC+1];
            converter_trigger_edge <= eif.pulse[NPRI+NSEC+2];
        end
    end

    // Read multiplexer; unmapped offsets read zero.
    always_comb begin
        case (reg_addr)
            ESR_OFS_POL_PRI: rd_mux = pol_pri_ff;
            ESR_OFS_POL_SEC: rd_mux = pol_sec_ff;
            ESR_OFS_EN_FIRST: rd_mux = en_first_ff;
            ESR_OFS_EN_SECOND: rd_mux = en_second_ff;
            ESR_OFS_FLAGS_A: rd_mux = flags_a_ff | ESR_EN_FIRST_FIXED;
            ESR_OFS_FLAGS_B: rd_mux = flags_b_ff;
            ESR_OFS_CTRL: rd_mux = {7'h00, gmask_ff};
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule : esr_regs
`default_nettype wire

// file: testbench/esr_regs_bench.sv
// Self-checking bench for the edge select and enable register block.
// Assumes the source model drives pins and events; one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module esr_regs_bench
    import esr_pkg::*;
;
    logic clk, nrst, reg_wr, reg_rd, any;
    logic [2:0] reg_addr, tpin, tedge;
    logic [7:0] reg_wdata, reg_rdata, sec, sec_e;
    logic [3:0] pri;
    logic [4:0] ev;
    logic [9:0] req;
    logic [10:0] seen;
    logic seen_clr;
    logic [7:0] rv [4] = '{8'h70, 8'h00, 8'h10, 8'h00};
    logic [7:0] wf [4] = '{8'h7f, 8'hff, 8'hdf, 8'hd0};
    int miscompares = 0;
    int num_checks = 0;
    // Clock of 5 ns period.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    esr_regs esr_regs_i (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .primary_pins(pri), .secondary_pins(sec),
        .timer_y_input_pin(tpin[2]), .timer_b_input_pin(tpin[1]),
        .converter_trigger_pin(tpin[0]), .timer_b1_overflow(ev[4]),
        .timer_a_overflow(ev[3]), .direct_transfer_event(ev[2]),
        .converter_end_event(ev[1]), .serial1_done_event(ev[0]),
        .timer_y_edge(tedge[2]), .timer_b_edge(tedge[1]),
        .converter_trigger_edge(tedge[0]), .secondary_edges(sec_e),
        .cpu_requests(req), .cpu_request_any(any));
    esr_src_model esr_src_model_i (.clk, .pri, .sec, .tpin, .ev);
    // Collects every edge pulse seen since the last clear.
    always @(posedge clk) seen <= seen_clr ? 11'h000 : seen | {sec_e, tedge};
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data is looked at in the one cycle where it stands.
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(11'(reg_rdata), 11'(exp));
    endtask : rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // Empties the pulse collector at the next edge.
    task automatic clr_seen;
        seen_clr <= 1'b1;
        @(posedge clk);
        seen_clr <= 1'b0;
    endtask : clr_seen
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : summarize
    // Cuts a hang short well beyond the expected run of some 150 cycles.
    initial begin
        #20000;
        miscompares++;
        summarize();
    end
    // Main sequence: registers, primary pins, events, secondary pins.
    initial begin
        nrst = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        seen_clr = 1'b1;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++) rd(3'(i), rv[i]);
        rd(3'h7, 8'h00);
        for (int i = 0; i < 4; i++) wr(3'(i), 8'hff);
        for (int i = 0; i < 4; i++) rd(3'(i), wf[i]);
        for (int i = 0; i < 4; i++) wr(3'(i), 8'h00);
        for (int i = 0; i < 4; i++) rd(3'(i), rv[i]);
        // Primary pins on falling edges, then on rising ones; flags set while disabled.
        wr(ESR_OFS_CTRL, 8'h00);
        esr_src_model_i.drive_pins(4'hf, 8'h00, 3'h0);
        cyc(6);
        rd(ESR_OFS_FLAGS_A, 8'h10);
        esr_src_model_i.drive_pins(4'h0, 8'h00, 3'h0);
        cyc(6);
        rd(ESR_OFS_FLAGS_A, 8'h1f);
        chk(11'(req), 11'h000);
        wr(ESR_OFS_EN_FIRST, 8'h0f);
        cyc(2);
        chk(11'(req), 11'h00f);
        wr(ESR_OFS_CTRL, 8'h01);
        cyc(2);
        chk(11'({any, req}), 11'h000);
        wr(ESR_OFS_FLAGS_A, 8'h00);
        rd(ESR_OFS_FLAGS_A, 8'h10);
        wr(ESR_OFS_POL_PRI, 8'h0f);
        esr_src_model_i.drive_pins(4'hf, 8'h00, 3'h0);
        cyc(6);
        rd(ESR_OFS_FLAGS_A, 8'h1f);
        wr(ESR_OFS_FLAGS_A, 8'h00);
        // Internal events reach the CPU only through their enables.
        wr(ESR_OFS_EN_FIRST, 8'hc0);
        wr(ESR_OFS_EN_SECOND, 8'hd0);
        wr(ESR_OFS_CTRL, 8'h00);
        esr_src_model_i.pulse(5'h1f);
        cyc(3);
        chk(11'({any, req}), 11'h5f0);
        rd(ESR_OFS_FLAGS_B, 8'hd0);
        wr(ESR_OFS_EN_SECOND, 8'h00);
        cyc(2);
        chk(11'(req), 11'h030);
        wr(ESR_OFS_EN_FIRST, 8'h00);
        cyc(2);
        chk(11'(req), 11'h000);
        // A reset in mid-run brings the written polarity back to its start.
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        rd(ESR_OFS_POL_PRI, 8'h70);
        // Secondary and shared pins: upper three rising, rest falling.
        wr(ESR_OFS_POL_SEC, 8'he0);
        clr_seen();
        esr_src_model_i.drive_pins(4'hf, 8'hff, 3'h7);
        cyc(8);
        chk(seen, {8'he0, 3'h7});
        clr_seen();
        esr_src_model_i.drive_pins(4'hf, 8'h00, 3'h0);
        cyc(8);
        chk(seen, {8'h1f, 3'h0});
        summarize();
    end
endmodule : esr_regs_bench
`default_nettype wire

// file: testbench/esr_regs_props.sv
// Checker for the edge select and enable register block.
// Assumes it is bound to esr_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module esr_regs_props
    import esr_pkg::*;
#(parameter int NPRI = 4, parameter int NSEC = 8) (
    // Clock, reset and read side of the register port.
    input wire logic clk,
    input wire logic nrst,
    input wire logic [2:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins and their edge pulses.
    input wire logic [NSEC-1:0] secondary_pins,
    input wire logic timer_y_input_pin,
    input wire logic timer_b_input_pin,
    input wire logic converter_trigger_pin,
    input wire logic timer_y_edge,
    input wire logic timer_b_edge,
    input wire logic converter_trigger_edge,
    input wire logic [NSEC-1:0] secondary_edges
);
    // All checks run on clk and rest while reset is low.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Fixed bits of the polarity and enable registers read back.
    property p_pri_fix;
        $past(reg_rd) && $past(reg_addr) == ESR_OFS_POL_PRI
            |-> reg_rdata[7:4] == 4'h7;
    endproperty
    a_pri_fix: assert property (p_pri_fix)
        else $error("primary polarity fixed bits wrong");
    property p_en1_fix;
        $past(reg_rd) && $past(reg_addr) == ESR_OFS_EN_FIRST
            |-> reg_rdata[5:4] == 2'h1;
    endproperty
    a_en1_fix: assert property (p_en1_fix)
        else $error("first enable fixed bits wrong");
    property p_en2_rsv;
        $past(reg_rd) && $past(reg_addr) == ESR_OFS_EN_SECOND
            |-> reg_rdata[5] == 1'b0 && reg_rdata[3:0] == 4'h0;
    endproperty
    a_en2_rsv: assert property (p_en2_rsv)
        else $error("second enable reserved bits set");
    // A pulse leaves three edges after its pin changed level.
    property p_edge_y;
        timer_y_edge |->
            $past(timer_y_input_pin, 3) != $past(timer_y_input_pin, 4);
    endproperty
    a_edge_y: assert property (p_edge_y)
        else $error("timer y pulse without pin change");
    property p_edge_b;
        timer_b_edge |->
            $past(timer_b_input_pin, 3) != $past(timer_b_input_pin, 4);
    endproperty
    a_edge_b: assert property (p_edge_b)
        else $error("timer b pulse without pin change");
    property p_edge_c;
        converter_trigger_edge |-> $past(converter_trigger_pin, 3)
            != $past(converter_trigger_pin, 4);
    endproperty
    a_edge_c: assert property (p_edge_c)
        else $error("trigger pulse without pin change");
    property p_edge_s;
        |secondary_edges |->
            $past(secondary_pins, 3) != $past(secondary_pins, 4);
    endproperty
    a_edge_s: assert property (p_edge_s)
        else $error("secondary pulse without pin change");
    // One edge gives one pulse: no timer b or secondary pulse bit stays high two cycles.
    property p_one;
        timer_b_edge || |secondary_edges
            |=> !timer_b_edge
                && (secondary_edges & $past(secondary_edges)) == '0;
    endproperty
    a_one: assert property (p_one)
        else $error("edge pulse longer than one cycle");
endmodule : esr_regs_props
bind esr_regs esr_regs_props #(.NPRI(NPRI), .NSEC(NSEC)) esr_regs_props_i (
    .clk, .nrst, .reg_addr, .reg_rd, .reg_rdata, .secondary_pins,
    .timer_y_input_pin, .timer_b_input_pin, .converter_trigger_pin,
    .timer_y_edge, .timer_b_edge, .converter_trigger_edge,
    .secondary_edges);
`default_nettype wire

// file: testbench/esr_src_model.sv
// Far-side model: external pin levels and one-cycle event pulses.
// Assumes the block samples everything on the rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module esr_src_model (
    // Clock.
    input wire logic clk,
    // Pin levels and event pulses.
    output logic [3:0] pri,
    output logic [7:0] sec,
    output logic [2:0] tpin,
    output logic [4:0] ev
);
    // Pins idle low so no edge is seen around reset.
    initial begin
        pri = 4'h0;
        sec = 8'h00;
        tpin = 3'h0;
        ev = 5'h00;
    end
    // Moves all pin levels together just after an edge.
    task automatic drive_pins(input logic [3:0] p, input logic [7:0] s,
                              input logic [2:0] t);
        @(posedge clk);
        pri <= p;
        sec <= s;
        tpin <= t;
    endtask : drive_pins
    // Raises the chosen event lines for exactly one cycle.
    task automatic pulse(input logic [4:0] v);
        @(posedge clk);
        ev <= v;
        @(posedge clk);
        ev <= 5'h00;
    endtask : pulse
endmodule : esr_src_model
`default_nettype wire
